/* File: hw/flow_thru_ssram_control_pins.sv */
/*
 * write buffer fifo and the pin-level control of a flow-through ssram.
 * assumes all pins but i_rst_b are synchronous to i_sys_clk and the bench resolves the
 * data bus from o_dq and o_dq_oe_n.
 */
`timescale 1ns/1ps

module ssram_wbuf_fifo
#(
	parameter int WIDTH = 73,
	parameter int DEPTH = 16,
	parameter int CNT_W = 5
)
(
	// clock and reset
	input  wire logic             i_sys_clk,
	input  wire logic             i_rst_b,
	// fill side
	input  wire logic             i_in_valid,
	output      logic             o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	// drain side
	output      logic             o_out_valid,
	input  wire logic             i_out_ready,
	output      logic [WIDTH-1:0] o_out_data,
	// fill level
	output      logic [CNT_W-1:0] o_count
);
	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PTR_W-1:0] wr_ptr_r;
	logic [PTR_W-1:0] rd_ptr_r;
	logic [CNT_W-1:0] count_r;
	wire              push = i_in_valid && o_in_ready;
	wire              pop  = o_out_valid && i_out_ready;

	assign o_in_ready  = count_r != CNT_W'(DEPTH);
	assign o_out_valid = count_r != '0;
	assign o_out_data  = store[rd_ptr_r];
	assign o_count     = count_r;

	// storage has no reset; only the pointers and the count carry state
	always_ff @(posedge i_sys_clk)
		if (push)
			store[wr_ptr_r] <= i_in_data;

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
		if (!i_rst_b)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end
		else
		begin
			wr_ptr_r <= push ? wr_ptr_r + 1'b1 : wr_ptr_r;
			rd_ptr_r <= pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
			count_r  <= count_r + CNT_W'(push) - CNT_W'(pop);
		end

	fifo_no_overrun_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		count_r <= CNT_W'(DEPTH))
		else $error("write buffer count above depth");
endmodule

module flow_thru_ssram_control_pins
	import ssram_ctl_pkg::*;
(
	// clock and reset
	input  wire logic              i_sys_clk,
	input  wire logic              i_rst_b,
	// synchronous control pins
	input  wire logic              i_clock_gate_n,
	input  wire logic              i_advance_or_load,
	input  wire logic              i_write_n,
	input  wire logic              i_pipeline_flush,
	input  wire logic              i_chip_select_a_n,
	input  wire logic              i_chip_select_b,
	input  wire logic              i_chip_select_c_n,
	input  wire logic [ADDR_W-1:0] i_addr,
	// output drive control and burst strap
	input  wire logic              i_output_enable_n,
	input  wire logic              i_burst_interleave,
	// data bus, split into in, out and enable
	input  wire logic [DATA_W-1:0] i_dq,
	output      logic [DATA_W-1:0] o_dq,
	output      logic              o_dq_oe_n,
	// write buffer has room
	output      logic              o_ready
);
	logic [DATA_W-1:0]  mem [2**ADDR_W];
	op_state_t          state_r, state_nxt;
	logic [ADDR_W-1:0]  cur_addr_r, cur_addr_nxt;
	logic [BURST_W-1:0] start_r, cnt_r, cnt_nxt;
	logic               dummy_r, dummy_nxt;
	logic               mode_r, mode_taken_r;
	logic [DATA_W-1:0]  wdata_r;
	logic               wvalid_r;
	logic [ADDR_W-1:0]  waddr_r;
	logic [DATA_W-1:0]  dq_r;
	logic               oe_n_r;
	logic               ready_r;
	wr_entry_t          wr_in, wr_out;
	logic               wbuf_in_ready, wbuf_out_valid;
	logic [WBUF_CNT_W-1:0] wbuf_count;

	// command decode at the pins
	wire qualified  = !i_clock_gate_n;
	wire selected   = !i_chip_select_a_n && i_chip_select_b && !i_chip_select_c_n;
	wire load       = qualified && !i_advance_or_load;
	wire start_acc  = load && selected;
	// advance only continues a live access; deselected it is a no-op
	wire advance    = qualified && i_advance_or_load && state_r != ST_DESEL;
	wire dummy_wr   = !i_write_n && i_pipeline_flush;
	wire data_phase = qualified && state_r == ST_WRITE && !dummy_r;

	// burst offset: linear adds, interleaved xors, both wrap mod four
	wire [BURST_W-1:0] cnt_inc  = cnt_r + 1'b1;
	wire [BURST_W-1:0] offs_nxt = mode_r ? (start_r ^ cnt_inc)
	                                     : (start_r + cnt_inc);
	wire [ADDR_W-1:0]  adv_addr = {cur_addr_r[ADDR_W-1:BURST_W], offs_nxt};
	wire [DATA_W-1:0]  rd_data  = mem[cur_addr_nxt];

	// next operation, address and counter
	always_comb
	begin
		state_nxt    = state_r;
		cur_addr_nxt = cur_addr_r;
		cnt_nxt      = cnt_r;
		dummy_nxt    = dummy_r;
		if (start_acc)
		begin
			state_nxt    = i_write_n ? ST_READ : ST_WRITE;
			cur_addr_nxt = i_addr;
			cnt_nxt      = BURST_RST;
			dummy_nxt    = dummy_wr;
		end
		else if (load)
			state_nxt = ST_DESEL;
		else if (advance)
		begin
			cur_addr_nxt = adv_addr;
			cnt_nxt      = cnt_inc;
		end
	end

	// output drive: read only, never while writing or deselected
	wire drive_nxt = state_nxt == ST_READ && !i_output_enable_n;

	// command registers; a gated edge leaves every one untouched
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
		if (!i_rst_b)
		begin
			state_r    <= ST_DESEL;
			cur_addr_r <= ADDR_RST;
			start_r    <= BURST_RST;
			cnt_r      <= BURST_RST;
			dummy_r    <= 1'b0;
		end
		else if (qualified)
		begin
			state_r    <= state_nxt;
			cur_addr_r <= cur_addr_nxt;
			start_r    <= start_acc ? i_addr[BURST_W-1:0] : start_r;
			cnt_r      <= cnt_nxt;
			dummy_r    <= dummy_nxt;
		end

	// strap caught on the first edge after reset release, then frozen
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
		if (!i_rst_b)
		begin
			mode_r       <= MODE_LINEAR;
			mode_taken_r <= 1'b0;
		end
		else if (!mode_taken_r)
		begin
			mode_r       <= i_burst_interleave;
			mode_taken_r <= 1'b1;
		end

	// input data register for the write data phase
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
		if (!i_rst_b)
		begin
			wdata_r  <= DQ_RST;
			waddr_r  <= ADDR_RST;
			wvalid_r <= 1'b0;
		end
		else
		begin
			wdata_r  <= data_phase ? i_dq : wdata_r;
			waddr_r  <= data_phase ? cur_addr_r : waddr_r;
			wvalid_r <= data_phase;
		end

	// read data and drive enable; flow-through, no extra stage
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
		if (!i_rst_b)
		begin
			dq_r    <= DQ_RST;
			oe_n_r  <= 1'b1;
		end
		else
		begin
			dq_r   <= (qualified && state_nxt == ST_READ) ? rd_data : dq_r;
			oe_n_r <= qualified ? !drive_nxt : (oe_n_r | i_output_enable_n);
		end

	// ready drops early so a data phase already under way still fits
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
		if (!i_rst_b)
			ready_r <= 1'b0;
		else
			ready_r <= wbuf_count < WBUF_HIGH_MARK;

	assign wr_in.addr = waddr_r;
	assign wr_in.data = wdata_r;

	// writes retire through the buffer; it stalls on every qualified edge whose next state is a read
	wire drain_ok = !(qualified && state_nxt == ST_READ);

	ssram_wbuf_fifo #(
		.WIDTH ($bits(wr_entry_t)),
		.DEPTH (WBUF_DEPTH),
		.CNT_W (WBUF_CNT_W)
	) u_wbuf (
		.i_sys_clk   (i_sys_clk),
		.i_rst_b     (i_rst_b),
		.i_in_valid  (wvalid_r),
		.o_in_ready  (wbuf_in_ready),
		.i_in_data   (wr_in),
		.o_out_valid (wbuf_out_valid),
		.i_out_ready (drain_ok),
		.o_out_data  (wr_out),
		.o_count     (wbuf_count)
	);

	// array write port fed only by the buffer
	always_ff @(posedge i_sys_clk)
		if (wbuf_out_valid && drain_ok)
			mem[wr_out.addr] <= wr_out.data;

	assign o_dq      = dq_r;
	assign o_dq_oe_n = oe_n_r;
	assign o_ready   = ready_r;

	// checks
	sequence gated_edge_s;
		i_clock_gate_n;
	endsequence

	sequence read_load_s;
		start_acc && i_write_n;
	endsequence

	gate_freezes_op_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		gated_edge_s |=> $stable(state_r) && $stable(cur_addr_r) && $stable(cnt_r))
		else $error("gated edge changed the operation");

	load_takes_addr_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		read_load_s |=> state_r == ST_READ && cur_addr_r == $past(i_addr) && cnt_r == 2'h0)
		else $error("read load did not register address");

	advance_counts_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		advance && !start_acc |=> cnt_r == $past(cnt_r) + 2'h1
		                          && cur_addr_r[ADDR_W-1:2] == $past(cur_addr_r[ADDR_W-1:2]))
		else $error("advance did not step the burst counter");

	burst_order_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		advance && !start_acc |=> cur_addr_r[1:0] ==
		    (mode_r ? (start_r ^ cnt_r) : (start_r + cnt_r)))
		else $error("burst offset out of order");

	float_unless_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		!o_dq_oe_n |-> state_r == ST_READ)
		else $error("data driven outside a read");

	drive_follows_oe_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		read_load_s ##0 !i_output_enable_n |=> !o_dq_oe_n)
		else $error("read with output enable not driven");

	flow_read_data_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		read_load_s |=> o_dq == $past(rd_data))
		else $error("read data not from preceding address");

	no_start_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		state_r == ST_DESEL && (i_clock_gate_n || i_advance_or_load || !selected)
		|=> state_r == ST_DESEL)
		else $error("access started without full select");

	capture_data_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		data_phase |=> wvalid_r && wdata_r == $past(i_dq) && waddr_r == $past(cur_addr_r))
		else $error("write data not captured");

	// a push into a full buffer would be lost silently
	wbuf_room_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		wvalid_r |-> wbuf_in_ready)
		else $error("write buffer full on push");

	write_floats_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		data_phase |-> o_dq_oe_n)
		else $error("data driven during write data phase");

	desel_floats_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		state_r == ST_DESEL |-> o_dq_oe_n)
		else $error("data driven while deselected");
endmodule

/* File: hw/ssram_ctl_pkg.sv */
/*
 * constants and carrier types for the flow-through ssram control block.
 * assumes a single 100 mhz clock and an active-low asynchronous reset.
 */
// Overview of operation
// - advance-or-load high at a qualified edge advances the burst counter.
// - advance-or-load low at a qualified edge loads a fresh address.
// - inputs captured on rising edge, only while clock gate is low; the strap and an output-enable release are taken on gated edges too.
// - clock gate high freezes operation and selection; previous cycle extends.
// - data pins driven while output-drive control low, inputs while high.
// - data pins float during write data phase, emerging clock, and deselect.
// - data pins acting as inputs are registered into a data register.
// - read outputs the location registered at the immediately preceding edge.
// - active-low reset returns the block to known state without the clock.
// - access starts with all selects active, clock gate and advance low.
// - two lowest address bits load the two-bit burst counter; here they load start_r and the counter clears to zero.
// - burst order comes from a strap: linear or interleaved.
package ssram_ctl_pkg;
	localparam int ADDR_W     = 21;
	localparam int DATA_W     = 52;
	localparam int BURST_W    = 2;
	localparam int WBUF_DEPTH = 16;
	localparam int WBUF_CNT_W = 5;
	// ready drops at this fill level, two entries early, to cover the one-cycle capture delay
	localparam logic [WBUF_CNT_W-1:0] WBUF_HIGH_MARK = 5'h0e;
	localparam logic [BURST_W-1:0]    BURST_RST      = 2'h0;
	localparam logic [DATA_W-1:0]     DQ_RST         = 52'h0;
	localparam logic [ADDR_W-1:0]     ADDR_RST       = 21'h0;
	localparam logic                  MODE_LINEAR    = 1'b0;

	typedef enum logic [1:0] {ST_DESEL, ST_READ, ST_WRITE} op_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} wr_entry_t;
endpackage

/* File: tb/flow_thru_ssram_control_pins_tb.sv */
/*
 * self-checking bench: random burst writes, flushes and burst reads.
 * assumes the design drains its write buffer during idle cycles.
 */
`timescale 1ns/1ps

module flow_thru_ssram_control_pins_tb;
	import ssram_ctl_pkg::*;
	logic              clk, rst_b, gate_n, adv, wr_n, flush, cs_a_n, cs_b, cs_c_n, oe_req_n, strap, drv_en;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] bus, dq_out, drv_data, d;
	logic              dq_oe_n, ready;
	logic [DATA_W-1:0] exp_mem [logic [ADDR_W-1:0]];
	logic [ADDR_W-1:0] bases [3];
	logic [1:0]        sts [3];
	int                mismatches, compares;

	flow_thru_ssram_control_pins i_dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_clock_gate_n(gate_n),
		.i_advance_or_load(adv), .i_write_n(wr_n), .i_pipeline_flush(flush), .i_chip_select_a_n(cs_a_n),
		.i_chip_select_b(cs_b), .i_chip_select_c_n(cs_c_n), .i_addr(addr), .i_output_enable_n(oe_req_n),
		.i_burst_interleave(strap), .i_dq(bus), .o_dq(dq_out), .o_dq_oe_n(dq_oe_n), .o_ready(ready));

	ssram_master_model i_master (.i_sys_clk(clk), .i_drive_en(drv_en), .i_drive_data(drv_data),
		.i_dev_dq(dq_out), .i_dev_dq_oe_n(dq_oe_n), .o_bus(bus));

	// burst word address: linear or interleaved, wrapping in the aligned group
	function automatic logic [ADDR_W-1:0] baddr(input logic [ADDR_W-1:0] b, input logic [1:0] s, input int k);
		logic [1:0] o;
		o = strap ? (s ^ 2'(k)) : (s + 2'(k));
		return {b[ADDR_W-1:2], o};
	endfunction

	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] want, input string what);
		compares++;
		if (got !== want)
		begin
			mismatches++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask

	// one pin cycle driven at an edge and taken at the next; the clock gate then
	// rises so the command is taken once only, and later edges stay idle
	task automatic drv(input logic g, a, w, s, f, o, input logic [ADDR_W-1:0] ad, input logic de,
		input logic [DATA_W-1:0] dd);
		@(posedge clk);
		gate_n <= g;
		adv <= a;
		wr_n <= w;
		cs_a_n <= !s;
		cs_b <= s;
		cs_c_n <= !s;
		flush <= f;
		oe_req_n <= o;
		addr <= ad;
		drv_en <= de;
		drv_data <= dd;
		@(posedge clk);
		gate_n <= 1'b1;
		#1;
	endtask

	task automatic conclude;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// free-running clock, 10 ns period
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// watchdog, far beyond the few hundred cycles the run needs
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		conclude();
	end

	initial
	begin
		{rst_b, adv, wr_n, flush, cs_b, strap, drv_en} = '0;
		{gate_n, cs_a_n, cs_c_n, oe_req_n} = '1;
		addr = '0;
		drv_data = '0;
		mismatches = 0;
		compares = 0;
		void'($urandom(32'hc54a0d4a));
		for (int m = 0; m < 2; m++)
		begin
			@(posedge clk);
			rst_b <= 1'b0;
			strap <= m[0];
			repeat (10) @(posedge clk);
			#1 chk(DATA_W'(dq_oe_n), DATA_W'(1'b1), "oe in reset");
			chk(DATA_W'(ready), DATA_W'(1'b0), "ready in reset");
			@(posedge clk);
			rst_b <= 1'b1;
			repeat (3) @(posedge clk);
			// burst writes, gated edges mixed in while the data is held
			for (int g = 0; g < 3; g++)
			begin
				bases[g] = ADDR_W'($urandom);
				sts[g] = 2'($urandom);
				drv(0, 0, 0, 1, 0, 0, baddr(bases[g], sts[g], 0), 0, '0);
				for (int k = 0; k < 4; k++)
				begin
					d = DATA_W'({$urandom, $urandom});
					exp_mem[baddr(bases[g], sts[g], k)] = d;
					if ($urandom_range(1))
						drv(1, 1'($urandom), 1'($urandom), 1'($urandom), 0, 0, ADDR_W'($urandom), 1, d);
					drv(0, k < 3, 0, k < 3, 0, 0, ADDR_W'($urandom), 1, d);
					chk(DATA_W'(dq_oe_n), DATA_W'(1'b1), "drive during write");
				end
			end
			// dummy writes to a written word drain the buffer and store nothing
			repeat (24) drv(0, 0, 0, 1, 1, 0, baddr(bases[0], sts[0], 0), 0, '0);
			drv(0, 1, 1, 0, 0, 0, '0, 0, '0);
			chk(DATA_W'(dq_oe_n), DATA_W'(1'b1), "drive in dummy write");
			chk(DATA_W'(ready), DATA_W'(1'b1), "ready after drain");
			// burst reads; the last group keeps the drive request off
			for (int g = 0; g < 3; g++)
			begin
				for (int j = 0; j < 4; j++)
				begin
					if (j > 0 && $urandom_range(1))
					begin
						drv(1, 1'($urandom), 1'($urandom), 1'($urandom), 0, g == 2, ADDR_W'($urandom), 0, '0);
						if (g < 2)
							chk(bus, exp_mem[baddr(bases[g], sts[g], j - 1)], "gated read");
					end
					// the address moves on advances to show that it is ignored then
					drv(0, j > 0, 1, 1, 0, g == 2, baddr(bases[g], sts[g], 0) ^ ADDR_W'(j > 0), 0, '0);
					chk(DATA_W'(dq_oe_n), DATA_W'(g == 2), "drive control");
					if (g < 2)
						chk(bus, exp_mem[baddr(bases[g], sts[g], j)], "read data");
				end
				// drive still requested here, yet a deselect must float the pins
				drv(0, 0, 1, 0, 0, 0, '0, 0, '0);
				chk(DATA_W'(dq_oe_n), DATA_W'(1'b1), "drive after deselect");
			end
		end
		conclude();
	end
endmodule

/* File: tb/ssram_master_model.sv */
/*
 * far-side bus model: resolves the shared data bus seen by the sram pins.
 * assumes the bench supplies write data and its drive enable per cycle.
 */
`timescale 1ns/1ps

module ssram_master_model
	import ssram_ctl_pkg::*;
(
	// clock
	input  wire logic              i_sys_clk,
	// master side write data
	input  wire logic              i_drive_en,
	input  wire logic [DATA_W-1:0] i_drive_data,
	// device side
	input  wire logic [DATA_W-1:0] i_dev_dq,
	input  wire logic              i_dev_dq_oe_n,
	// resolved bus
	output      logic [DATA_W-1:0] o_bus
);
	logic [DATA_W-1:0] last_r = '0;

	// no pull on the bus, so a released bus shows the inverse of its last value
	assign o_bus = !i_dev_dq_oe_n ? i_dev_dq :
		(i_drive_en ? i_drive_data : ~last_r);

	// remember the bus for the released case
	always_ff @(posedge i_sys_clk)
		last_r <= o_bus;
endmodule
